/* src/ctm_pkg.sv */
package ctm_pkg;

  // register offsets
  localparam logic [7:0] NTC_THRESHOLD_SELECT_ADDR = 8'h0e;
  localparam logic [7:0] IMPEDANCE_TEST_CONFIG_ADDR = 8'h0f;
  localparam logic [7:0] INTERRUPT_MASK_BITS_ADDR = 8'h10;
  localparam logic [7:0] SOURCE_DETECT_STATUS_ADDR = 8'h11;
  localparam logic [7:0] INPUT_WATCHDOG_STATUS_ADDR = 8'h12;
  localparam logic [7:0] PROBE_STATUS_ADDR = 8'h16;

  // threshold select field positions (lsb)
  localparam int HOT_LEVEL_POS = 6;
  localparam int WARM_LEVEL_POS = 4;
  localparam int COOL_LEVEL_POS = 2;
  localparam int COLD_LEVEL_POS = 0;

  // reset values
  localparam logic [1:0] HOT_LEVEL_RST = 2'h2;
  localparam logic [1:0] WARM_LEVEL_RST = 2'h1;
  localparam logic [1:0] COOL_LEVEL_RST = 2'h2;
  localparam logic [1:0] COLD_LEVEL_RST = 2'h1;
  localparam logic [7:0] NTC_THRESHOLD_RST = {HOT_LEVEL_RST, WARM_LEVEL_RST, COOL_LEVEL_RST, COLD_LEVEL_RST};

  // impedance test config field positions
  localparam int PROBE_ENABLE_POS = 6;
  localparam int PROBE_CURRENT_POS = 2;
  localparam int PROBE_COMPARE_POS = 0;
  localparam logic [6:0] IMPEDANCE_TEST_RST = 7'h00;
  localparam logic [3:0] PROBE_CURRENT_MAX = 4'h8;

  // mask bit positions
  localparam int THERMAL_IRQ_MASK_BIT = 5;
  localparam int POWER_REG_IRQ_MASK_BIT = 4;
  localparam int TOPUP_TIMER_IRQ_MASK_BIT = 3;
  localparam int CONFIG_CHANNEL_IRQ_MASK_BIT = 2;
  localparam int LOW_CELL_IRQ_MASK_BIT = 1;
  localparam int ACCESSORY_IRQ_MASK_BIT = 0;
  localparam logic [1:0] MASK_RESERVED_VAL = 2'h1;

  // input-valid debounce
  localparam int CLK_MHZ = 100;
  localparam int VALID_DEBOUNCE_US = 15000;
  localparam int VALID_DEBOUNCE_CYCLES = VALID_DEBOUNCE_US * CLK_MHZ;

  // serial port
  localparam logic [6:0] DEVICE_ADDR_DEFAULT = 7'h3f;
  localparam logic [3:0] ACK_PHASE = 4'h8;
  localparam logic [3:0] ACK_DONE = 4'h9;

  typedef enum logic [2:0] {
    CTM_IDLE,
    CTM_DEV,
    CTM_PTR,
    CTM_WDATA,
    CTM_RDATA
  } ctm_state_t;

endpackage

/* src/ctm_regs.sv */
`timescale 1ns/1ps
`default_nettype none

module ctm_regs #(
  parameter logic [6:0] DEVICE_ADDR = ctm_pkg::DEVICE_ADDR_DEFAULT,
  parameter int DEBOUNCE_CYCLES = ctm_pkg::VALID_DEBOUNCE_CYCLES,
  parameter logic THERMAL_MASK_OTP = 1'b0,
  parameter logic CHANNEL_MASK_OTP = 1'b0
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  // serial control port
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  // status from the analog and charging side
  input wire logic [3:0] source_detect_result_i,
  input wire logic input_voltage_regulation_i,
  input wire logic input_current_regulation_i,
  input wire logic input_in_window_i,
  input wire logic input_ready_flag_i,
  input wire logic old_cable_flag_i,
  input wire logic thermal_reg_flag_i,
  input wire logic system_floor_flag_i,
  input wire logic watchdog_expired_i,
  input wire logic watchdog_warning_flag_i,
  input wire logic probe_compare_reached_i,
  input wire logic topup_timer_i,
  input wire logic low_cell_event_i,
  input wire logic sink_channel_status_i,
  input wire logic source_channel_status_i,
  input wire logic debug_accessory_flag_i,
  input wire logic audio_accessory_flag_i,
  // configuration to the analog side, then the power good pin and interrupt pulse
  output logic [1:0] hot_level_sel_o,
  output logic [1:0] warm_level_sel_o,
  output logic [1:0] cool_level_sel_o,
  output logic [1:0] cold_level_sel_o,
  output logic inlet_probe_enable_o,
  output logic [3:0] probe_current_sel_o,
  output logic [1:0] probe_compare_sel_o,
  output logic power_good_pin_n_o,
  output logic irq_pulse_o
);

  localparam int CW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam logic [CW-1:0] DBC_LAST = CW'(DEBOUNCE_CYCLES - 1);
  localparam logic [5:0] MASK_RST = {THERMAL_MASK_OTP, 2'b00, CHANNEL_MASK_OTP, 2'b00};

  typedef struct packed {
    ctm_pkg::ctm_state_t st;
    logic scl_q;
    logic sda_q;
    logic [3:0] bitcnt;
    logic [7:0] shreg;
    logic [7:0] ptr;
    logic sda_oe;
    logic sda_out;
    logic [7:0] ntc;
    logic [6:0] probe;
    logic [5:0] mask;
    logic [3:0] src_det;
    logic vdpm;
    logic idpm;
    logic valid;
    logic ready;
    logic cable;
    logic therm;
    logic sysfl;
    logic wdf;
    logic wdb;
    logic pcmp;
    logic dbg;
    logic aud;
    logic [CW-1:0] dbc;
    logic pg_n;
    logic irq;
  } ctm_state_rec_t;

  ctm_state_rec_t cur_r;
  ctm_state_rec_t cur_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // read mux

  function automatic logic [7:0] ctm_read(input ctm_state_rec_t s, input logic [7:0] a);
    logic [7:0] d;
    d = 8'h00;
    unique case (a)
      ctm_pkg::NTC_THRESHOLD_SELECT_ADDR: d = s.ntc;
      ctm_pkg::IMPEDANCE_TEST_CONFIG_ADDR: d = {1'b0, s.probe};
      ctm_pkg::INTERRUPT_MASK_BITS_ADDR: d = {ctm_pkg::MASK_RESERVED_VAL, s.mask};
      ctm_pkg::SOURCE_DETECT_STATUS_ADDR:
        d = {
          s.src_det,
          2'b00,
          s.vdpm,
          s.idpm
        };
      ctm_pkg::INPUT_WATCHDOG_STATUS_ADDR:
        d = {
          1'b0,
          s.valid,
          s.ready,
          s.cable,
          s.therm,
          s.sysfl,
          s.wdf,
          s.wdb
        };
      ctm_pkg::PROBE_STATUS_ADDR: d = {5'h00, s.pcmp, 2'b00};
      default: d = 8'h00;
    endcase
    return d;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // next state

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic [7:0] wbyte;
  logic [3:0] cur_code;
  logic masked_evt;
  logic always_evt;
  logic thermal_chg;
  logic power_reg_chg;
  logic topup_evt;
  logic channel_evt;
  logic low_cell_evt;
  logic accessory_evt;
  logic valid_chg;
  logic ready_rise;
  logic expiry_rise;
  logic warning_rise;
  logic probe_chg;

  always_comb
  begin
    cur_nxt = cur_r;
    scl_rise = scl_i & ~cur_r.scl_q;
    scl_fall = ~scl_i & cur_r.scl_q;
    start_cond = scl_i & cur_r.scl_q & cur_r.sda_q & ~sda_i;
    stop_cond = scl_i & cur_r.scl_q & ~cur_r.sda_q & sda_i;
    wbyte = cur_r.shreg;
    cur_code = wbyte[ctm_pkg::PROBE_CURRENT_POS +: 4];
    cur_nxt.scl_q = scl_i;
    cur_nxt.sda_q = sda_i;
    cur_nxt.sda_out = 1'b0;

    // serial port engine
    if (start_cond)
    begin
      cur_nxt.st = ctm_pkg::CTM_DEV;
      cur_nxt.bitcnt = 4'h0;
      cur_nxt.sda_oe = 1'b0;
    end
    else if (stop_cond)
    begin
      cur_nxt.st = ctm_pkg::CTM_IDLE;
      cur_nxt.sda_oe = 1'b0;
    end
    else if (cur_r.st != ctm_pkg::CTM_IDLE)
    begin
      if (scl_rise)
      begin
        if (cur_r.bitcnt < ctm_pkg::ACK_PHASE)
        begin
          cur_nxt.shreg = {cur_r.shreg[6:0], sda_i};
          cur_nxt.bitcnt = cur_r.bitcnt + 4'h1;
        end
        else if (cur_r.st == ctm_pkg::CTM_RDATA && cur_r.bitcnt == ctm_pkg::ACK_DONE && sda_i)
          cur_nxt.st = ctm_pkg::CTM_IDLE; // master nack ends the read
      end
      else if (scl_fall)
      begin
        if (cur_r.st == ctm_pkg::CTM_RDATA)
        begin
          if (cur_r.bitcnt == ctm_pkg::ACK_DONE)
          begin
            cur_nxt.shreg = ctm_read(cur_r, cur_r.ptr);
            cur_nxt.ptr = cur_r.ptr + 8'h01;
            cur_nxt.bitcnt = 4'h0;
            cur_nxt.sda_oe = ~cur_nxt.shreg[7];
          end
          else if (cur_r.bitcnt == ctm_pkg::ACK_PHASE)
          begin
            cur_nxt.sda_oe = 1'b0;
            cur_nxt.bitcnt = ctm_pkg::ACK_DONE;
          end
          else
            cur_nxt.sda_oe = ~cur_r.shreg[7]; // each rise shifts the byte up, so the next bit is on top
        end
        else if (cur_r.bitcnt == ctm_pkg::ACK_PHASE)
        begin
          cur_nxt.bitcnt = ctm_pkg::ACK_DONE;
          cur_nxt.sda_oe = 1'b1;
          unique case (cur_r.st)
            ctm_pkg::CTM_DEV:
            begin
              if (wbyte[7:1] != DEVICE_ADDR)
              begin
                cur_nxt.st = ctm_pkg::CTM_IDLE;
                cur_nxt.sda_oe = 1'b0;
              end
              else if (wbyte[0])
                cur_nxt.st = ctm_pkg::CTM_RDATA;
            end
            ctm_pkg::CTM_PTR:
              cur_nxt.ptr = wbyte;
            ctm_pkg::CTM_WDATA:
            begin
              cur_nxt.ptr = cur_r.ptr + 8'h01;
              unique case (cur_r.ptr)
                ctm_pkg::NTC_THRESHOLD_SELECT_ADDR:
                begin
                  cur_nxt.ntc[ctm_pkg::HOT_LEVEL_POS +: 2] = wbyte[ctm_pkg::HOT_LEVEL_POS +: 2];
                  cur_nxt.ntc[ctm_pkg::WARM_LEVEL_POS +: 2] = wbyte[ctm_pkg::WARM_LEVEL_POS +: 2];
                  cur_nxt.ntc[ctm_pkg::COOL_LEVEL_POS +: 2] = wbyte[ctm_pkg::COOL_LEVEL_POS +: 2];
                  cur_nxt.ntc[ctm_pkg::COLD_LEVEL_POS +: 2] = wbyte[ctm_pkg::COLD_LEVEL_POS +: 2];
                end
                ctm_pkg::IMPEDANCE_TEST_CONFIG_ADDR:
                begin
                  cur_nxt.probe[ctm_pkg::PROBE_ENABLE_POS] = wbyte[ctm_pkg::PROBE_ENABLE_POS];
                  cur_nxt.probe[ctm_pkg::PROBE_COMPARE_POS +: 2] = wbyte[ctm_pkg::PROBE_COMPARE_POS +: 2];
                  if (cur_code > ctm_pkg::PROBE_CURRENT_MAX)
                    cur_nxt.probe[ctm_pkg::PROBE_CURRENT_POS +: 4] = ctm_pkg::PROBE_CURRENT_MAX;
                  else
                    cur_nxt.probe[ctm_pkg::PROBE_CURRENT_POS +: 4] = cur_code;
                end
                ctm_pkg::INTERRUPT_MASK_BITS_ADDR: cur_nxt.mask = wbyte[5:0];
                default: ;
              endcase
            end
            default: ;
          endcase
        end
        else if (cur_r.bitcnt == ctm_pkg::ACK_DONE)
        begin
          // release ack; a read never gets here, its first bit is driven from the RDATA branch
          cur_nxt.sda_oe = 1'b0;
          cur_nxt.bitcnt = 4'h0;
          if (cur_r.st == ctm_pkg::CTM_DEV)
            cur_nxt.st = ctm_pkg::CTM_PTR;
          else if (cur_r.st == ctm_pkg::CTM_PTR)
            cur_nxt.st = ctm_pkg::CTM_WDATA;
        end
      end
    end
    // dev-ack with read bit moved to RDATA at ACK_PHASE; first byte loads on the next fall, at ACK_DONE

    // status sampling
    cur_nxt.src_det = source_detect_result_i;
    cur_nxt.vdpm = input_voltage_regulation_i;
    cur_nxt.idpm = input_current_regulation_i;
    cur_nxt.ready = input_ready_flag_i;
    cur_nxt.cable = old_cable_flag_i;
    cur_nxt.therm = thermal_reg_flag_i;
    cur_nxt.sysfl = system_floor_flag_i;
    cur_nxt.wdf = watchdog_expired_i;
    cur_nxt.wdb = watchdog_warning_flag_i;
    cur_nxt.pcmp = probe_compare_reached_i;
    cur_nxt.dbg = debug_accessory_flag_i;
    cur_nxt.aud = audio_accessory_flag_i;

    // input valid debounce: sets only after a full quiet window, drops at once
    if (!input_in_window_i)
    begin
      cur_nxt.dbc = '0;
      cur_nxt.valid = 1'b0;
    end
    else if (!cur_r.valid)
    begin
      if (cur_r.dbc == DBC_LAST)
        cur_nxt.valid = 1'b1;
      else
        cur_nxt.dbc = cur_r.dbc + CW'(1);
    end
    cur_nxt.pg_n = ~cur_nxt.valid;

    // watchdog expiry restores its fields; masks keep their value
    if (watchdog_expired_i && !cur_r.wdf)
    begin
      cur_nxt.ntc = ctm_pkg::NTC_THRESHOLD_RST;
      cur_nxt.probe = ctm_pkg::IMPEDANCE_TEST_RST;
    end

    // interrupts: a mask suppresses only the pulse, flags update regardless
    thermal_chg = thermal_reg_flag_i != cur_r.therm;
    power_reg_chg =
      (input_voltage_regulation_i != cur_r.vdpm) | (input_current_regulation_i != cur_r.idpm);
    topup_evt = topup_timer_i;
    channel_evt = sink_channel_status_i | source_channel_status_i | (old_cable_flag_i != cur_r.cable);
    low_cell_evt = low_cell_event_i;
    accessory_evt = (debug_accessory_flag_i & ~cur_r.dbg) | (audio_accessory_flag_i & ~cur_r.aud);
    valid_chg = cur_nxt.valid != cur_r.valid;
    ready_rise = input_ready_flag_i & ~cur_r.ready;
    expiry_rise = watchdog_expired_i & ~cur_r.wdf;
    warning_rise = watchdog_warning_flag_i & ~cur_r.wdb;
    probe_chg = probe_compare_reached_i != cur_r.pcmp;
    masked_evt =
      (thermal_chg & ~cur_r.mask[ctm_pkg::THERMAL_IRQ_MASK_BIT]) |
      (power_reg_chg & ~cur_r.mask[ctm_pkg::POWER_REG_IRQ_MASK_BIT]) |
      (topup_evt & ~cur_r.mask[ctm_pkg::TOPUP_TIMER_IRQ_MASK_BIT]) |
      (channel_evt & ~cur_r.mask[ctm_pkg::CONFIG_CHANNEL_IRQ_MASK_BIT]) |
      (low_cell_evt & ~cur_r.mask[ctm_pkg::LOW_CELL_IRQ_MASK_BIT]) |
      (accessory_evt & ~cur_r.mask[ctm_pkg::ACCESSORY_IRQ_MASK_BIT]);
    always_evt = valid_chg | ready_rise | expiry_rise | warning_rise | probe_chg;
    cur_nxt.irq = masked_evt | always_evt;
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register

  always_ff @(posedge mclk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      cur_r <= '0;
      cur_r.st <= ctm_pkg::CTM_IDLE;
      cur_r.scl_q <= 1'b1;
      cur_r.sda_q <= 1'b1;
      cur_r.ntc <= ctm_pkg::NTC_THRESHOLD_RST;
      cur_r.probe <= ctm_pkg::IMPEDANCE_TEST_RST;
      cur_r.mask <= MASK_RST;
      cur_r.pg_n <= 1'b1;
    end
    else
      cur_r <= cur_nxt;
  end

  assign sda_o = cur_r.sda_out;
  assign sda_oe_o = cur_r.sda_oe;
  assign hot_level_sel_o = cur_r.ntc[ctm_pkg::HOT_LEVEL_POS +: 2];
  assign warm_level_sel_o = cur_r.ntc[ctm_pkg::WARM_LEVEL_POS +: 2];
  assign cool_level_sel_o = cur_r.ntc[ctm_pkg::COOL_LEVEL_POS +: 2];
  assign cold_level_sel_o = cur_r.ntc[ctm_pkg::COLD_LEVEL_POS +: 2];
  assign inlet_probe_enable_o = cur_r.probe[ctm_pkg::PROBE_ENABLE_POS];
  assign probe_current_sel_o = cur_r.probe[ctm_pkg::PROBE_CURRENT_POS +: 4];
  assign probe_compare_sel_o = cur_r.probe[ctm_pkg::PROBE_COMPARE_POS +: 2];
  assign power_good_pin_n_o = cur_r.pg_n;
  assign irq_pulse_o = cur_r.irq;

endmodule // ctm_regs

`default_nettype wire

/* verification/ctm_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ctm_checker #(
  parameter int DEBOUNCE_CYCLES = 20
) (
  input wire logic mclk_i,
  input wire logic rst_i,
  input wire logic input_in_window_i,
  input wire logic input_ready_flag_i,
  input wire logic watchdog_expired_i,
  input wire logic watchdog_warning_flag_i,
  input wire logic probe_compare_reached_i,
  input wire logic [1:0] hot_level_sel_o,
  input wire logic [1:0] cold_level_sel_o,
  input wire logic [3:0] probe_current_sel_o,
  input wire logic power_good_pin_n_o,
  input wire logic irq_pulse_o
);
  int cnt_r;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////
  // in-window run length, saturating so it never wraps
  always_ff @(posedge mclk_i or posedge rst_i)
    if (rst_i)
      cnt_r <= 0;
    else if (!input_in_window_i)
      cnt_r <= 0;
    else if (cnt_r < DEBOUNCE_CYCLES + 8)
      cnt_r <= cnt_r + 1;
  probe_cur_a: assert property (probe_current_sel_o <= 4'h8)
    else $error("probe current above top code");
  ready_irq_a: assert property ($rose(input_ready_flag_i) |=> irq_pulse_o)
    else $error("ready rise without irq");
  wd_irq_a: assert property ($rose(watchdog_expired_i) |=> irq_pulse_o)
    else $error("expiry without irq");
  warn_irq_a: assert property ($rose(watchdog_warning_flag_i) |=> irq_pulse_o)
    else $error("warning without irq");
  probe_irq_a: assert property ($changed(probe_compare_reached_i) |=> irq_pulse_o)
    else $error("probe change without irq");
  pg_early_a: assert property (!power_good_pin_n_o |-> cnt_r >= DEBOUNCE_CYCLES - 1)
    else $error("power good before debounce");
  pg_late_a: assert property (cnt_r >= DEBOUNCE_CYCLES + 3 |-> !power_good_pin_n_o)
    else $error("power good missing");
  pg_drop_a: assert property ($fell(input_in_window_i) |-> ##[1:2] power_good_pin_n_o)
    else $error("power good held");
  valid_irq_a: assert property ($fell(power_good_pin_n_o) |-> ##[0:1] irq_pulse_o)
    else $error("input valid without irq");
  wd_restore_a: assert property ($rose(watchdog_expired_i) |-> ##[1:3]
    (hot_level_sel_o == ctm_pkg::HOT_LEVEL_RST && cold_level_sel_o == ctm_pkg::COLD_LEVEL_RST))
    else $error("thresholds not restored");
endmodule // ctm_checker

bind ctm_regs ctm_checker #(.DEBOUNCE_CYCLES(DEBOUNCE_CYCLES)) u_chk (.mclk_i(mclk_i), .rst_i(rst_i),
  .input_in_window_i(input_in_window_i), .input_ready_flag_i(input_ready_flag_i),
  .watchdog_expired_i(watchdog_expired_i), .watchdog_warning_flag_i(watchdog_warning_flag_i),
  .probe_compare_reached_i(probe_compare_reached_i), .hot_level_sel_o(hot_level_sel_o),
  .cold_level_sel_o(cold_level_sel_o), .probe_current_sel_o(probe_current_sel_o),
  .power_good_pin_n_o(power_good_pin_n_o), .irq_pulse_o(irq_pulse_o));
`default_nettype wire

/* verification/ctm_host.sv */
`timescale 1ns/1ps
`default_nettype none
module ctm_host (
  input wire logic mclk_i,
  input wire logic sda_i,
  output logic scl_o,
  output logic sda_o
);
  logic [7:0] q;
  logic a;
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end
  ////////////////////////////////////////
  // every change lands 1 ns after an edge
  task automatic tk(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  // slow levels: the port needs at least 4 clocks per level
  task automatic bx(input logic b, output logic r);
    sda_o = b;
    tk(5);
    scl_o = 1'b1;
    tk(3);
    r = sda_i;
    tk(3);
    scl_o = 1'b0;
    tk(2);
  endtask
  task automatic by(input logic [7:0] d, input logic m, output logic [7:0] r, output logic k);
    for (int i = 7; i >= 0; i--)
      bx(d[i], r[i]);
    bx(m, k);
  endtask
  task automatic start;
    sda_o = 1'b1;
    tk(3);
    scl_o = 1'b1;
    tk(4);
    sda_o = 1'b0;
    tk(4);
    scl_o = 1'b0;
    tk(2);
  endtask
  task automatic stop;
    sda_o = 1'b0;
    tk(3);
    scl_o = 1'b1;
    tk(4);
    sda_o = 1'b1;
    tk(4);
  endtask
  task automatic wr(input logic [6:0] dv, input logic [7:0] ad, input logic [7:0] d, output logic k);
    logic k1;
    logic k2;
    start();
    by({dv, 1'b0}, 1'b1, q, k);
    by(ad, 1'b1, q, k1);
    by(d, 1'b1, q, k2);
    stop();
    k = k | k1 | k2;
  endtask
  task automatic rd(input logic [7:0] ad, output logic [7:0] d);
    start();
    by({ctm_pkg::DEVICE_ADDR_DEFAULT, 1'b0}, 1'b1, q, a);
    by(ad, 1'b1, q, a);
    start();
    by({ctm_pkg::DEVICE_ADDR_DEFAULT, 1'b1}, 1'b1, q, a);
    by(8'hff, 1'b1, d, a);
    stop();
  endtask
endmodule // ctm_host
`default_nettype wire

/* verification/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  localparam int DEB = 20;
  logic mclk_i, rst_i, scl, sda_h, sda_oe, sda_d, sda, pen, pg_n, irq, k;
  logic [19:0] st;
  logic [1:0] hot, warm, cool, cold, pcmp;
  logic [3:0] pcur;
  logic [7:0] q;
  int num_errors, total_checks, n;
  // open-drain line with pull-up
  // the device puts its data value on the line only while enabled
  assign sda = sda_h & (sda_oe ? sda_d : 1'b1);
  ctm_host host (.mclk_i(mclk_i), .sda_i(sda), .scl_o(scl), .sda_o(sda_h));
  ctm_regs #(.DEBOUNCE_CYCLES(DEB)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .scl_i(scl), .sda_i(sda),
    .sda_o(sda_d), .sda_oe_o(sda_oe), .source_detect_result_i(st[19:16]), .input_voltage_regulation_i(st[0]),
    .input_current_regulation_i(st[1]), .thermal_reg_flag_i(st[2]), .old_cable_flag_i(st[3]),
    .topup_timer_i(st[4]), .low_cell_event_i(st[5]), .sink_channel_status_i(st[6]),
    .source_channel_status_i(st[7]), .debug_accessory_flag_i(st[8]), .audio_accessory_flag_i(st[9]),
    .input_in_window_i(st[10]), .input_ready_flag_i(st[11]), .system_floor_flag_i(st[12]),
    .watchdog_expired_i(st[13]), .watchdog_warning_flag_i(st[14]), .probe_compare_reached_i(st[15]),
    .hot_level_sel_o(hot), .warm_level_sel_o(warm), .cool_level_sel_o(cool), .cold_level_sel_o(cold),
    .inlet_probe_enable_o(pen), .probe_current_sel_o(pcur), .probe_compare_sel_o(pcmp),
    .power_good_pin_n_o(pg_n), .irq_pulse_o(irq));
  ////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.wr(ctm_pkg::DEVICE_ADDR_DEFAULT, a, d, k);
    chk(k, 1'b0);
  endtask
  // raise one source, count irq cycles; sources 4..7 are one-cycle pulses
  task automatic fire(input int i, input logic exp);
    n = 0;
    st[i] = 1'b1;
    for (int c = 0; c < 4; c++)
    begin
      @(posedge mclk_i);
      #1;
      if (c == 0 && i >= 4 && i <= 7)
        st[i] = 1'b0;
      if (irq === 1'b1)
        n++;
    end
    st[i] = 1'b0;
    repeat (4) @(posedge mclk_i);
    #1;
    chk(n > 0, exp);
  endtask
  task automatic t_reset;
    host.rd(8'h0e, q);
    chk(q, 8'h99);
    chk({hot, warm, cool, cold}, 8'h99);
    host.rd(8'h0f, q);
    chk(q, 8'h00);
    chk({pen, pcur, pcmp}, 7'h00);
    host.rd(8'h10, q);
    chk(q, 8'h40);
  endtask
  task automatic t_cfg;
    logic [1:0] v;
    logic [3:0] u;
    logic [3:0] e;
    for (int c = 0; c < 4; c++)
    begin
      v = 2'(c);
      wr(8'h0e, {4{v}});
      chk({hot, warm, cool, cold}, {4{v}});
      // codes above 1000 saturate
      u = (c == 3) ? 4'hf : 4'(c * 4);
      e = (u > 4'h8) ? 4'h8 : u;
      wr(8'h0f, {1'b1, v[0], u, v});
      chk({pen, pcur, pcmp}, {v[0], e, v});
      host.rd(8'h0f, q);
      chk(q, {1'b0, v[0], e, v});
    end
  endtask
  task automatic t_mask;
    int mb[10] = '{4, 4, 5, 2, 3, 1, 2, 2, 0, 0};
    for (int i = 0; i < 10; i++)
    begin
      wr(8'h10, 8'h01 << mb[i]);
      fire(i, 1'b0);
      wr(8'h10, ~(8'h01 << mb[i]));
      fire(i, 1'b1);
    end
  endtask
  task automatic t_always;
    wr(8'h0e, 8'h00);
    wr(8'h0f, 8'h41);
    wr(8'h10, 8'hff);
    fire(11, 1'b1);
    fire(14, 1'b1);
    fire(15, 1'b1);
    fire(12, 1'b0);
    fire(16, 1'b0);
    fire(13, 1'b1);
    host.rd(8'h0e, q);
    chk(q, 8'h99);
    host.rd(8'h0f, q);
    chk(q, 8'h00);
    host.rd(8'h10, q);
    chk(q, 8'h7f);
  endtask
  // all masks set: status must still follow the inputs
  task automatic t_status;
    logic [19:0] pat[2] = '{20'he_d80d, 20'h1_2002};
    logic [23:0] exp[2] = '{24'he2_3d_04, 24'h11_02_00};
    for (int i = 0; i < 2; i++)
    begin
      st = pat[i];
      host.rd(8'h11, q);
      chk(q, exp[i][23:16]);
      host.rd(8'h12, q);
      chk(q, exp[i][15:8]);
      host.rd(8'h16, q);
      chk(q & 8'h04, exp[i][7:0]);
    end
    st = '0;
  endtask
  task automatic t_valid;
    st[10] = 1'b1;
    repeat (DEB - 2) @(posedge mclk_i);
    #1;
    chk(pg_n, 1'b1);
    repeat (5) @(posedge mclk_i);
    #1;
    chk(pg_n, 1'b0);
    host.rd(8'h12, q);
    chk(q[6], 1'b1);
    st[10] = 1'b0;
    repeat (3) @(posedge mclk_i);
    #1;
    chk(pg_n, 1'b1);
  endtask
  task automatic t_bus;
    host.wr(7'h2a, 8'h10, 8'h00, k);
    chk(k, 1'b1);
    host.rd(8'h10, q);
    chk(q, 8'h7f);
    wr(8'h11, 8'hff);
    host.rd(8'h11, q);
    chk(q, 8'h00);
    host.rd(8'h20, q);
    chk(q, 8'h00);
  endtask
  task automatic print_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  initial
  begin
    mclk_i = 1'b0;
    forever #5 mclk_i = ~mclk_i;
  end
  initial
  begin
    num_errors = 0;
    total_checks = 0;
    st = '0;
    rst_i = 1'b1;
    repeat (3) @(posedge mclk_i);
    #1;
    rst_i = 1'b0;
    repeat (2) @(posedge mclk_i);
    #1;
    t_reset();
    t_cfg();
    t_mask();
    t_always();
    t_status();
    t_valid();
    t_bus();
    print_verdict();
  end
  // about four times the expected run
  initial
  begin
    #1000000;
    num_errors++;
    print_verdict();
  end
endmodule // tb
`default_nettype wire
